// [dv/somsel_motor.sv]
`timescale 1ns/10ps
// ==========================================================
// Motor model: a halt brings it to rest after a few cycles.
module somsel_motor #(
  parameter int DECEL = 3
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic halt_request,
  input  wire logic motor_moving,
  output logic      motor_standstill
);
  int cnt;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) cnt <= 0;
    else if (!halt_request) cnt <= 0;
    else if (cnt < DECEL) cnt <= cnt + 1;
  end
  // Rest is reached once the deceleration has run its course, or at once while motor_moving is low.
  assign motor_standstill = !motor_moving || (cnt == DECEL);
endmodule

// [dv/tb_servo_operating_mode_select.sv]
`timescale 1ns/10ps
module tb_servo_operating_mode_select;
  import somsel_pkg::*;
  logic core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
  logic [15:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
  logic reg_rvalid, power_enabled = 0, activate_cfg = 0, activate_in = 0;
  logic switch_cfg = 0, switch_in = 0, motor_moving = 0, motor_standstill;
  logic mode_terminated = 0, gear_pos_sync = 0;
  logic [1:0] halt_ramp_select = 0, halt_ramp;
  logic [2:0] active_mode;
  logic mode_running, halt_request, change_refused;
  int failures = 0, tests_run = 0;
  always #20 core_clk = ~core_clk;
  somsel_top somsel_top_i (.core_clk(core_clk), .rst_n(rst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .power_enabled(power_enabled), .activate_cfg(activate_cfg),
    .activate_in(activate_in), .switch_cfg(switch_cfg),
    .switch_in(switch_in), .mode_terminated(mode_terminated),
    .motor_moving(motor_moving), .gear_pos_sync(gear_pos_sync),
    .motor_standstill(motor_standstill),
    .halt_ramp_select(halt_ramp_select), .active_mode(active_mode),
    .mode_running(mode_running), .halt_request(halt_request),
    .halt_ramp(halt_ramp), .change_refused(change_refused));
  somsel_motor somsel_motor_i (.core_clk(core_clk), .rst_n(rst_n),
    .halt_request(halt_request), .motor_moving(motor_moving),
    .motor_standstill(motor_standstill));
  // ==========================================================
  // Bus and check tasks.
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk({15'h0000, reg_rvalid}, 16'h0001);
    chk(reg_rdata, e);
  endtask
  function automatic logic [15:0] mon(input int k);
    case (k)
      0: return {13'h0000, active_mode};
      1: return {15'h0000, halt_request};
      2: return {15'h0000, change_refused};
      default: return {15'h0000, mode_running};
    endcase
  endfunction
  // A wait that never sees its value counts as a failure and ends the run.
  task automatic wfor(input int k, input logic [15:0] e);
    int n;
    for (n = 0; n < 60 && mon(k) !== e; n++) @(negedge core_clk);
    chk(mon(k), e);
    if (mon(k) !== e) tally_and_finish();
  endtask
  task automatic power_on;
    rst_n <= 1'b0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask
  // ==========================================================
  // Main sequence.
  initial begin
    power_on();
    rd(SOMSEL_ADDR_DEFAULT, 16'h0005);
    rd(SOMSEL_ADDR_ALTERNATE, 16'h0000);
    wr(SOMSEL_ADDR_DEFAULT, 16'h0004);
    rd(SOMSEL_ADDR_DEFAULT, 16'h0005);
    wr(SOMSEL_ADDR_ALTERNATE, 16'h0004);
    rd(SOMSEL_ADDR_ALTERNATE, 16'h0000);
    wr(SOMSEL_ADDR_ALTERNATE, 16'h0002);
    rd(SOMSEL_ADDR_ALTERNATE, 16'h0002);
    wr(SOMSEL_ADDR_DEFAULT, 16'h0003);
    rd(SOMSEL_ADDR_DEFAULT, 16'h0003);
    @(posedge core_clk);
    power_enabled <= 1'b1;
    wfor(0, 16'h0005);
    wr(SOMSEL_ADDR_DEFAULT, 16'h0001);
    rd(SOMSEL_ADDR_DEFAULT, 16'h0003);
    @(posedge core_clk);
    motor_moving <= 1'b1;
    switch_cfg <= 1'b1;
    switch_in <= 1'b1;
    wfor(0, 16'h0002);
    chk({15'h0000, halt_request}, 16'h0000);
    @(posedge core_clk);
    halt_ramp_select <= 2'h2;
    switch_in <= 1'b0;
    wfor(1, 16'h0001);
    chk({14'h0000, halt_ramp}, 16'h0002);
    wfor(0, 16'h0005);
    chk({15'h0000, halt_request}, 16'h0000);
    wr(SOMSEL_ADDR_ALTERNATE, 16'h0000);
    switch_in <= 1'b1;
    wfor(2, 16'h0001);
    chk({13'h0000, active_mode}, 16'h0005);
    // A terminated mode may change even into none while moving.
    @(posedge core_clk);
    mode_terminated <= 1'b1;
    wfor(0, 16'h0000);
    chk({15'h0000, mode_running}, 16'h0001);
    @(posedge core_clk);
    mode_terminated <= 1'b0;
    gear_pos_sync <= 1'b1;
    wr(SOMSEL_ADDR_ALTERNATE, 16'h0003);
    wfor(1, 16'h0001);
    wfor(0, 16'h0003);
    @(posedge core_clk);
    switch_cfg <= 1'b0;
    wfor(0, 16'h0005);
    @(posedge core_clk);
    gear_pos_sync <= 1'b0;
    switch_cfg <= 1'b1;
    wfor(0, 16'h0003);
    chk({15'h0000, halt_request}, 16'h0000);
    @(posedge core_clk);
    switch_in <= 1'b0;
    motor_moving <= 1'b0;
    power_enabled <= 1'b0;
    power_on();
    activate_cfg <= 1'b1;
    power_enabled <= 1'b1;
    repeat (6) @(negedge core_clk);
    chk({15'h0000, mode_running}, 16'h0000);
    @(posedge core_clk);
    activate_in <= 1'b1;
    wfor(3, 16'h0001);
    tally_and_finish();
  end
endmodule

// [shared/somsel_pkg.sv]
// Contract
// [R1] Default codes 0 none, 1 torque, 2 velocity, 3 gear, 5 jog; reset is 5.
// [R2] A default write is taken only while the power stage is disabled.
// [R3] A new default value takes effect only at the next power-on; here reset reloads 5, so a written value never takes effect.
// [R4] Enabling power starts the default mode unless activate is configured.
// [R5] With activate configured, only its rising edge starts the mode.
// [R6] A mode change is allowed once the active mode has terminated.
// [R7] In motion, changes are allowed only among jog, gear, torque, velocity.
// [R8] Entering jog or position-synced gearing first stops; others do not.
// [R9] A standstill change brakes with the halt ramp selection, then enters.
// [R10] With mode-switch configured, asserting it selects the alternate mode.
// [R11] Alternate codes 0 to 3, reset is 0, and a write acts at once.
// [R12] Undefined mode codes are refused and leave the selector unchanged.
package somsel_pkg;

  localparam logic [15:0] SOMSEL_ADDR_DEFAULT   = 16'h0506;
  localparam logic [15:0] SOMSEL_ADDR_ALTERNATE = 16'h065e;

  localparam logic [2:0] SOMSEL_MODE_NONE   = 3'h0;
  localparam logic [2:0] SOMSEL_MODE_TORQUE = 3'h1;
  localparam logic [2:0] SOMSEL_MODE_VELOC  = 3'h2;
  localparam logic [2:0] SOMSEL_MODE_GEAR   = 3'h3;
  localparam logic [2:0] SOMSEL_MODE_JOG    = 3'h5;

  localparam logic [2:0] SOMSEL_DEFAULT_RST   = SOMSEL_MODE_JOG;
  localparam logic [2:0] SOMSEL_ALTERNATE_RST = SOMSEL_MODE_NONE;

  typedef enum logic [3:0] {
    SOMSEL_IDLE  = 4'b0001,
    SOMSEL_RUN   = 4'b0010,
    SOMSEL_HALT  = 4'b0100,
    SOMSEL_ENTER = 4'b1000
  } somsel_state_e;

endpackage

// [verilog/somsel_top.sv]
`timescale 1ns/10ps
module somsel_top
  import somsel_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  output logic             reg_rvalid,
  input  wire logic        power_enabled,
  input  wire logic        activate_cfg,
  input  wire logic        activate_in,
  input  wire logic        switch_cfg,
  input  wire logic        switch_in,
  input  wire logic        mode_terminated,
  input  wire logic        motor_moving,
  input  wire logic        gear_pos_sync,
  input  wire logic        motor_standstill,
  input  wire logic [1:0]  halt_ramp_select,
  output logic      [2:0]  active_mode,
  output logic             mode_running,
  output logic             halt_request,
  output logic      [1:0]  halt_ramp,
  output logic             change_refused
);

  typedef struct packed {
    logic [2:0]    dflt_stored;
    logic [2:0]    dflt_eff;
    logic [2:0]    alt_sel;
    logic [2:0]    act;
    logic [2:0]    pend;
    somsel_state_e st;
    logic          pwr_d;
    logic          act_d;
    logic          refused;
    logic          halt;
    logic [1:0]    ramp;
    logic [15:0]   rdata;
    logic          rvalid;
    logic          run;
  } somsel_s;

  somsel_s st_r;
  somsel_s st_nxt;
  logic    rst_sync1_r;
  logic    rst_sync2_r;

  default clocking chk_clk @(posedge core_clk);
  endclocking
  default disable iff (!rst_sync2_r);

  // ============================================================
  // Reset release
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync1_r <= 1'b0;
      rst_sync2_r <= 1'b0;
    end else begin
      rst_sync1_r <= 1'b1;
      rst_sync2_r <= rst_sync1_r;
    end
  end

  // ============================================================
  // Mode selection
  logic [2:0] want_mode;
  logic       start_ev;
  logic       needs_stop;
  logic       want_ok;
  logic       dflt_ok;
  logic       alt_ok;

  always_comb begin
    want_mode = (switch_cfg && switch_in) ? st_r.alt_sel
                                          : st_r.dflt_eff; // R10
    // Enabling only starts the mode when no activate input is assigned.
    start_ev = activate_cfg ? (activate_in && !st_r.act_d) // R5
                            : (power_enabled && !st_r.pwr_d); // R4
    needs_stop = (want_mode == SOMSEL_MODE_JOG) ||
                 (want_mode == SOMSEL_MODE_GEAR && gear_pos_sync); // R8
    want_ok = (want_mode == SOMSEL_MODE_JOG) ||
              (want_mode == SOMSEL_MODE_GEAR) ||
              (want_mode == SOMSEL_MODE_TORQUE) ||
              (want_mode == SOMSEL_MODE_VELOC); // R7
    dflt_ok = (reg_wdata[15:3] == 13'h0000) &&
              (reg_wdata[2:0] <= SOMSEL_MODE_GEAR ||
               reg_wdata[2:0] == SOMSEL_MODE_JOG); // R12
    alt_ok = (reg_wdata[15:3] == 13'h0000) &&
             (reg_wdata[2:0] <= SOMSEL_MODE_GEAR); // R12
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.pwr_d = power_enabled;
    st_nxt.act_d = activate_in;
    st_nxt.refused = 1'b0;
    st_nxt.rvalid = reg_rd;
    if (reg_wr && reg_addr == SOMSEL_ADDR_DEFAULT && !power_enabled &&
        dflt_ok) begin
      st_nxt.dflt_stored = reg_wdata[2:0]; // R2 R3
    end
    if (reg_wr && reg_addr == SOMSEL_ADDR_ALTERNATE && alt_ok) begin
      st_nxt.alt_sel = reg_wdata[2:0]; // R11
    end
    if (reg_rd) begin
      case (reg_addr)
        SOMSEL_ADDR_DEFAULT:   st_nxt.rdata = {13'h0000, st_r.dflt_stored};
        SOMSEL_ADDR_ALTERNATE: st_nxt.rdata = {13'h0000, st_r.alt_sel};
        default:               st_nxt.rdata = 16'h0000;
      endcase
    end
    case (st_r.st)
      SOMSEL_IDLE: begin
        if (power_enabled && start_ev && want_mode != SOMSEL_MODE_NONE) begin
          st_nxt.act = want_mode;
          st_nxt.st = SOMSEL_RUN;
        end
      end
      SOMSEL_RUN: begin
        if (!power_enabled) begin
          // Clearing the mode on the way back to idle lets active_mode
          // come straight from its flop instead of a decode of the state.
          st_nxt.act = SOMSEL_MODE_NONE;
          st_nxt.st = SOMSEL_IDLE;
        end else if (want_mode != st_r.act) begin
          if (mode_terminated) begin
            st_nxt.act = want_mode; // R6
          end else if (motor_moving && !want_ok) begin
            st_nxt.refused = 1'b1; // R7
          end else if (needs_stop) begin
            st_nxt.pend = want_mode;
            st_nxt.halt = 1'b1; // R9
            st_nxt.ramp = halt_ramp_select; // R9
            st_nxt.st = SOMSEL_HALT;
          end else begin
            st_nxt.act = want_mode; // R8
          end
        end
      end
      SOMSEL_HALT: begin
        if (!power_enabled) begin
          st_nxt.act = SOMSEL_MODE_NONE;
          st_nxt.halt = 1'b0;
          st_nxt.st = SOMSEL_IDLE;
        end else if (motor_standstill) begin
          st_nxt.halt = 1'b0;
          st_nxt.st = SOMSEL_ENTER; // R8
        end
      end
      SOMSEL_ENTER: begin
        st_nxt.act = st_r.pend; // R9
        st_nxt.st = SOMSEL_RUN;
      end
      default: begin
        st_nxt.act = SOMSEL_MODE_NONE;
        st_nxt.halt = 1'b0;
        st_nxt.st = SOMSEL_IDLE;
      end
    endcase
    st_nxt.run = (st_nxt.st != SOMSEL_IDLE);
  end

  always_ff @(posedge core_clk or negedge rst_sync2_r) begin
    if (!rst_sync2_r) begin
      st_r <= '{dflt_stored: SOMSEL_DEFAULT_RST, dflt_eff: SOMSEL_DEFAULT_RST,
                alt_sel: SOMSEL_ALTERNATE_RST, act: SOMSEL_MODE_NONE,
                pend: SOMSEL_MODE_NONE, st: SOMSEL_IDLE, pwr_d: 1'b0,
                act_d: 1'b0, refused: 1'b0, halt: 1'b0, ramp: 2'h0,
                rdata: 16'h0000, rvalid: 1'b0, run: 1'b0}; // R1 R11
    end else begin
      st_r <= st_nxt;
    end
  end

  // Power-on is modelled by reset, but reset loads SOMSEL_DEFAULT_RST into both
  // dflt_stored and dflt_eff, so a stored value never reaches dflt_eff.
  assign active_mode    = st_r.act;
  assign mode_running   = st_r.run;
  assign halt_request   = st_r.halt;
  assign halt_ramp      = st_r.ramp;
  assign change_refused = st_r.refused;
  assign reg_rdata      = st_r.rdata;
  assign reg_rvalid     = st_r.rvalid;

  // ============================================================
  // Checks
  chk_dflt_locked: assert property ( // R2
    power_enabled |=> $stable(st_r.dflt_stored))
    else $error("Default selector changed while power stage enabled.");

  chk_eff_frozen: assert property ( // R3
    ##1 $stable(st_r.dflt_eff))
    else $error("Effective default mode changed without power-on.");

  chk_auto_start: assert property ( // R4
    (st_r.st == SOMSEL_IDLE && !activate_cfg && power_enabled &&
     !st_r.pwr_d && want_mode != SOMSEL_MODE_NONE) |=> mode_running)
    else $error("Mode not started on power stage enable.");

  chk_act_edge: assert property ( // R5
    (st_r.st == SOMSEL_IDLE && activate_cfg &&
     !(activate_in && !st_r.act_d)) |=> !mode_running)
    else $error("Mode started without activate edge.");

  chk_term_change: assert property ( // R6
    (st_r.st == SOMSEL_RUN && power_enabled && mode_terminated)
    |=> active_mode == $past(want_mode))
    else $error("Mode not changed after termination.");

  chk_halt_ramp: assert property ( // R9
    $rose(halt_request) |-> halt_ramp == $past(halt_ramp_select))
    else $error("Halt ramp not taken from selection.");

  chk_enter_stop: assert property ( // R8
    (st_r.st == SOMSEL_HALT && power_enabled && motor_standstill)
    |=> ##1 active_mode == $past(st_r.pend, 2))
    else $error("Pending mode not entered after standstill.");

  chk_no_stop: assert property ( // R8
    (st_r.st == SOMSEL_RUN && power_enabled && !mode_terminated &&
     want_mode != st_r.act && want_ok && !needs_stop)
    |=> !halt_request && active_mode == $past(want_mode))
    else $error("Change without standstill was delayed.");

  chk_refuse_mode: assert property ( // R7
    change_refused |-> $stable(active_mode))
    else $error("Refused change altered the mode.");

  chk_alt_range: assert property ( // R11 R12
    st_r.alt_sel <= SOMSEL_MODE_GEAR &&
    (st_r.dflt_stored <= SOMSEL_MODE_GEAR ||
     st_r.dflt_stored == SOMSEL_MODE_JOG))
    else $error("Selector holds an undefined code.");

  chk_read_answer: assert property ( // R1 R11
    reg_rd |=> reg_rvalid)
    else $error("Read not answered in the next cycle.");

endmodule
